// file: hdl/ssf_event_if.sv
/*
  interface carrying the serial engine events between flag keeper and top.
  assumes one clock domain; events are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
interface ssf_event_if;
  logic rxDone;
  logic txStart;
  logic txDone;
  logic bufRead;
  logic startSeen;
  logic stopSeen;
  logic portEn;
  logic i2cMode;
  logic bufFull;
  logic startFlag;
  logic stopFlag;
  modport src (output rxDone, txStart, txDone, bufRead, startSeen, stopSeen,
               output portEn, i2cMode, input bufFull, startFlag, stopFlag);
  modport dst (input rxDone, txStart, txDone, bufRead, startSeen, stopSeen,
               input portEn, i2cMode, output bufFull, startFlag, stopFlag);
endinterface
`default_nettype wire

// file: hdl/ssf_flag_keeper.sv
/*
  keeps buffer full, start-seen and stop-seen flags.
  assumes event pulses already in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ssf_flag_keeper
  import ssf_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  sys_rst,
  ssf_event_if.dst   ev
);
  logic bfReg, bfNext;
  logic startReg, startNext;
  logic stopReg, stopNext;
  logic i2cTx;

  assign i2cTx = ev.i2cMode && ev.txStart;
  // set wins over the read that empties the buffer
  assign bfNext = (!ev.portEn) ? 1'b0 :
                  (ev.rxDone || i2cTx) ? 1'b1 :
                  ((ev.i2cMode && ev.txDone) || ev.bufRead) ? 1'b0 : bfReg;
  // last detected condition wins; disable clears both
  assign stopNext = (!ev.portEn || !ev.i2cMode) ? 1'b0 :
                    ev.stopSeen ? 1'b1 :
                    ev.startSeen ? 1'b0 : stopReg;
  // a stop in the same cycle as a start counts as the later one
  assign startNext = (!ev.portEn || !ev.i2cMode) ? 1'b0 :
                     ev.stopSeen ? 1'b0 :
                     ev.startSeen ? 1'b1 : startReg;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      bfReg    <= 1'b0;
      startReg <= 1'b0;
      stopReg  <= 1'b0;
    end
    else
    begin
      bfReg    <= bfNext;
      startReg <= startNext;
      stopReg  <= stopNext;
    end
  end

  assign ev.bufFull   = bfReg;
  assign ev.startFlag = startReg;
  assign ev.stopFlag  = stopReg;
endmodule
`default_nettype wire

// file: hdl/ssf_irq_bank.sv
/*
  sticky interrupt status with write-one-to-clear and a mask.
  assumes event pulses on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ssf_irq_bank
#(
  parameter int N = 4
)
(
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [N-1:0] events,
  input  wire logic [N-1:0] clearBits,
  input  wire logic         maskWr,
  input  wire logic [N-1:0] maskData,
  output logic      [N-1:0] status,
  output logic      [N-1:0] mask,
  output logic              irq
);
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          status[i] <= 1'b0;
        else if (events[i])
          status[i] <= 1'b1;
        else if (clearBits[i])
          status[i] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      mask <= '0;
    else if (maskWr)
      mask <= maskData;
  end

  assign irq = |(status & mask);
endmodule
`default_nettype wire

// file: hdl/ssf_pkg.sv
/*
  package of the serial port status flag block: register map, fields, resets.
  assumes an apb slave with 32-bit data and one aligned word per register.
*/
package ssf_pkg;
  localparam logic [7:0] SSF_OFS_STATUS  = 8'h00;
  localparam logic [7:0] SSF_OFS_CONTROL = 8'h04;
  localparam logic [7:0] SSF_OFS_DATA    = 8'h08;
  localparam logic [7:0] SSF_OFS_IRQSTAT = 8'h0C;
  localparam logic [7:0] SSF_OFS_IRQMASK = 8'h10;
  localparam int SSF_BIT_SMP  = 7;
  localparam int SSF_BIT_EDGE = 6;
  localparam int SSF_BIT_STOP = 4;
  localparam int SSF_BIT_STRT = 3;
  localparam int SSF_BIT_BF   = 0;
  localparam int SSF_CTL_EN   = 0;
  localparam int SSF_CTL_I2C  = 1;
  localparam int SSF_CTL_SLV  = 2;
  localparam int SSF_IRQ_RX   = 0;
  localparam int SSF_IRQ_TX   = 1;
  localparam int SSF_IRQ_STRT = 2;
  localparam int SSF_IRQ_STOP = 3;
  localparam logic [7:0] SSF_RST_STATUS  = 8'h00;
  localparam logic [2:0] SSF_RST_CONTROL = 3'h0;
  localparam logic [3:0] SSF_RST_MASK    = 4'h0;
endpackage

// file: hdl/ssf_status_top.sv
/*
  status register bank of a synchronous serial port in spi or i2c mode.
  assumes an apb master on clock and engine events on the same clock;
  the raw start/stop detector lines come from pin logic and are resynchronised.
*/
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ssf_status_top
  import ssf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxDone,
  input  wire logic [7:0]  rxByte,
  input  wire logic        txStart,
  input  wire logic        txDone,
  input  wire logic        startPin,
  input  wire logic        stopPin,
  output logic             portEnable,
  output logic             i2cSelect,
  output logic             slaveSelect,
  output logic             samplePhase,
  output logic             clockEdge,
  output logic             irq
);
  ssf_event_if ev ();

  logic [2:0] ctlReg;
  logic [1:0] phaseReg;
  logic [7:0] dataReg;
  logic [1:0] startSync, stopSync;
  logic       startLast, stopLast;
  logic [3:0] irqStat, irqMask, irqEvents, irqClear;

  wire access   = psel && penable;
  wire wrAcc    = access && pwrite && pstrb[0];
  wire rdAcc    = access && !pwrite;
  wire hitStat  = (paddr == SSF_OFS_STATUS);
  wire hitCtl   = (paddr == SSF_OFS_CONTROL);
  wire hitData  = (paddr == SSF_OFS_DATA);
  wire hitIStat = (paddr == SSF_OFS_IRQSTAT);
  wire hitIMask = (paddr == SSF_OFS_IRQMASK);
  wire mapped   = hitStat | hitCtl | hitData | hitIStat | hitIMask;
  wire startEdge = startSync[1] && !startLast;
  wire stopEdge  = stopSync[1] && !stopLast;
  // the sample phase bit is forced low in i2c or spi slave configuration
  wire phaseLock = ctlReg[SSF_CTL_I2C] || ctlReg[SSF_CTL_SLV];

  wire [7:0] statusWord = {phaseReg[1], phaseReg[0], 1'b0, ev.stopFlag,
                           ev.startFlag, 2'b00, ev.bufFull};

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ctlReg   <= SSF_RST_CONTROL;
      phaseReg <= 2'b00;
    end
    else
    begin
      if (wrAcc && hitCtl)
        ctlReg <= pwdata[2:0];
      if (wrAcc && hitStat)
        phaseReg <= {pwdata[SSF_BIT_SMP] && !phaseLock, pwdata[SSF_BIT_EDGE]};
      else if (phaseLock)
        phaseReg[1] <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      dataReg <= 8'h00;
    else if (rxDone)
      dataReg <= rxByte;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      startSync <= 2'b00;
      stopSync  <= 2'b00;
      startLast <= 1'b0;
      stopLast  <= 1'b0;
    end
    else
    begin
      startSync <= {startSync[0], startPin};
      stopSync  <= {stopSync[0], stopPin};
      startLast <= startSync[1];
      stopLast  <= stopSync[1];
    end
  end

  assign ev.rxDone    = rxDone;
  assign ev.txStart   = txStart;
  assign ev.txDone    = txDone;
  assign ev.bufRead   = rdAcc && hitData;
  assign ev.startSeen = startEdge && ctlReg[SSF_CTL_I2C];
  assign ev.stopSeen  = stopEdge && ctlReg[SSF_CTL_I2C];
  assign ev.portEn    = ctlReg[SSF_CTL_EN];
  assign ev.i2cMode   = ctlReg[SSF_CTL_I2C];

  ssf_flag_keeper u_flags (
    .clock   (clock),
    .sys_rst (sys_rst),
    .ev      (ev)
  );

  assign irqEvents = {ev.stopSeen, ev.startSeen, txDone, rxDone};
  assign irqClear  = (wrAcc && hitIStat) ? pwdata[3:0] : 4'h0;

  ssf_irq_bank #(.N(4)) u_irq (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .events    (irqEvents),
    .clearBits (irqClear),
    .maskWr    (wrAcc && hitIMask),
    .maskData  (pwdata[3:0]),
    .status    (irqStat),
    .mask      (irqMask),
    .irq       (irq)
  );

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h0000_0000;
      if (paddr == SSF_OFS_STATUS)
        prdata[7:0] <= statusWord;
      else if (paddr == SSF_OFS_CONTROL)
        prdata[2:0] <= ctlReg;
      else if (paddr == SSF_OFS_DATA)
        prdata[7:0] <= dataReg;
      else if (paddr == SSF_OFS_IRQSTAT)
        prdata[3:0] <= irqStat;
      else if (paddr == SSF_OFS_IRQMASK)
        prdata[3:0] <= irqMask;
    end
  end

  assign pready      = 1'b1;
  assign pslverr     = access && !mapped;
  assign portEnable  = ctlReg[SSF_CTL_EN];
  assign i2cSelect   = ctlReg[SSF_CTL_I2C];
  assign slaveSelect = ctlReg[SSF_CTL_SLV];
  assign samplePhase = phaseReg[1];
  assign clockEdge   = phaseReg[0];
endmodule
`default_nettype wire

// file: test/ssf_serial_peer.sv
/* serial partner model: engine events and bus condition pins.
   assumes the bench calls its tasks just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module ssf_serial_peer
(
  input  wire logic  clock,
  output logic       rxDone,
  output logic [7:0] rxByte,
  output logic       txStart,
  output logic       txDone,
  output logic       startPin,
  output logic       stopPin
);
  initial {rxDone, rxByte, txStart, txDone, startPin, stopPin} = '0;
  // kind 0 receive done, 1 transmit start, 2 transmit done
  task automatic pulse(input int k, input logic [7:0] b);
    rxByte <= b;
    case (k)
      0: rxDone <= 1'b1;
      1: txStart <= 1'b1;
      default: txDone <= 1'b1;
    endcase
    @(posedge clock);
    {rxDone, txStart, txDone} <= 3'h0;
    rxByte <= ~b;
  endtask
  task automatic cond(input logic stp);
    if (stp)
      stopPin <= 1'b1;
    else
      startPin <= 1'b1;
    repeat (3) @(posedge clock);
    {startPin, stopPin} <= 2'h0;
    repeat (3) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// file: test/ssf_status_props.sv
/* port checker of the status bank.
   assumes it is bound onto ssf_status_top. */
`timescale 1ns/1ps
`default_nettype none
module ssf_status_props
  import ssf_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        rxDone,
  input wire logic        txStart,
  input wire logic        portEnable,
  input wire logic        i2cSelect,
  input wire logic        slaveSelect,
  input wire logic        samplePhase
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire rdStat = psel && !penable && !pwrite && paddr == SSF_OFS_STATUS;
  property p_smpSlave; slaveSelect && $past(slaveSelect) |-> !samplePhase; endproperty
  a_smpSlave: assert property (p_smpSlave) else $error("phase set in slave");
  property p_smpI2c; i2cSelect && $past(i2cSelect) |-> !samplePhase; endproperty
  a_smpI2c: assert property (p_smpI2c) else $error("phase set in i2c");
  property p_bfRx; rxDone && portEnable ##1 rdStat |=> prdata[SSF_BIT_BF]; endproperty
  a_bfRx: assert property (p_bfRx) else $error("full not set by rx");
  property p_bfTx;
    txStart && i2cSelect && portEnable ##1 rdStat |=> prdata[SSF_BIT_BF];
  endproperty
  a_bfTx: assert property (p_bfTx) else $error("full not set by tx");
  property p_oneCond; rdStat |=> !(prdata[SSF_BIT_STOP] && prdata[SSF_BIT_STRT]); endproperty
  a_oneCond: assert property (p_oneCond) else $error("start and stop both");
  property p_flagsOff;
    rdStat && !(portEnable && i2cSelect) && !($past(portEnable) && $past(i2cSelect))
      |=> prdata[SSF_BIT_STOP:SSF_BIT_STRT] == 2'h0;
  endproperty
  a_flagsOff: assert property (p_flagsOff) else $error("cond flag when off");
endmodule
bind ssf_status_top ssf_status_props u_props (.clock, .sys_rst, .psel, .penable, .pwrite,
  .paddr, .prdata, .rxDone, .txStart, .portEnable, .i2cSelect, .slaveSelect, .samplePhase);
`default_nettype wire

// file: test/tb_sync_serial_status_flags.sv
/* self-checking bench of the status bank.
   assumes the peer model drives the engine side. */
`timescale 1ns/1ps
`default_nettype none
module tb_sync_serial_status_flags
  import ssf_pkg::*;
;
  logic        clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0, rxByte;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0]  pstrb = '0;
  logic        pready, pslverr, irq, rxDone, txStart, txDone, startPin, stopPin;
  logic        slvErr, phaseOut, edgeOut;
  int          err_count = 0, comparisons = 0, sample_phase_select = 0, ce = 0, bf = 0, st = 0, sp = 0, b;
  int          m[2] = '{5, 3};
  always #4 clock = ~clock;
  ssf_status_top DUT (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .rxDone, .rxByte, .txStart, .txDone, .startPin, .stopPin,
    .portEnable(), .i2cSelect(), .slaveSelect(), .samplePhase(phaseOut),
    .clockEdge(edgeOut), .irq);
  ssf_serial_peer P (.clock, .rxDone, .rxByte, .txStart, .txDone, .startPin, .stopPin);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic stat;
    bus(1'b0, SSF_OFS_STATUS, 32'h0);
    chk(rd, 32'(sample_phase_select * 128 + ce * 64 + sp * 16 + st * 8 + bf));
    chk({31'h0, slvErr}, 32'h0);
    chk({31'h0, phaseOut}, 32'(sample_phase_select));
    chk({31'h0, edgeOut}, 32'(ce));
  endtask
  task automatic test_done;
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    b = $urandom(32'h77938b63);
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    stat;
    bus(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, slvErr}, 32'h1);
    foreach (m[i])
    begin
      bus(1'b1, SSF_OFS_CONTROL, 32'h1);
      bus(1'b1, SSF_OFS_STATUS, 32'hC0);
      sample_phase_select = 1;
      ce = 1;
      stat;
      bus(1'b1, SSF_OFS_CONTROL, 32'(m[i]));
      sample_phase_select = 0;
      stat;
      bus(1'b1, SSF_OFS_STATUS, 32'h80);
      ce = 0;
      stat;
    end
    bus(1'b1, SSF_OFS_IRQMASK, 32'hF);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, SSF_OFS_CONTROL, 32'(1 + 2 * (i % 2)));
      b = $urandom % 256;
      P.pulse(0, b[7:0]);
      bf = 1;
      stat;
      bus(1'b0, SSF_OFS_DATA, 32'h0);
      chk(rd, 32'(b));
      bf = 0;
      stat;
      P.pulse(1, 8'h00);
      bf = i % 2;
      stat;
      P.pulse(2, 8'h00);
      bf = 0;
      stat;
    end
    P.cond(1'b0);
    st = 1;
    stat;
    P.cond(1'b1);
    st = 0;
    sp = 1;
    stat;
    P.cond(1'b0);
    st = 1;
    sp = 0;
    stat;
    P.pulse(1, 8'h0);
    bf = 1;
    stat;
    P.pulse(2, 8'h0);
    bf = 0;
    stat;
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, SSF_OFS_IRQSTAT, 32'hF);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, SSF_OFS_IRQMASK, 32'h0);
    P.pulse(0, 8'h5A);
    bf = 1;
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, SSF_OFS_IRQSTAT, 32'h0);
    chk(rd, 32'h1);
    P.cond(1'b1);
    st = 0;
    sp = 1;
    stat;
    bus(1'b1, SSF_OFS_CONTROL, 32'h2);
    sp = 0;
    bf = 0;
    stat;
    test_done;
  end
  initial
  begin
    #200000;
    err_count++;
    test_done;
  end
endmodule
`default_nettype wire
